// file: design/div_pkg.sv
/*
  Shared types and constants of the integer divide unit: opcodes,
  divide forms, condition flags, request and result carriers.
  Assumes a 16-bit core with a paired multiply/divide register.
*/
`default_nettype none

package div_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned DIV_STEPS = 32;      // One quotient bit per cycle

  // ----------------------------------------------------------------
  // First instruction byte of each divide form
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_SIGNED_SHORT   = 8'h4b;
  localparam logic [7:0] OPC_UNSIGNED_SHORT = 8'h5b;
  localparam logic [7:0] OPC_SIGNED_LONG    = 8'h6b;
  localparam logic [7:0] OPC_UNSIGNED_LONG  = 8'h7b;

  // ----------------------------------------------------------------
  // Special operand values
  // ----------------------------------------------------------------
  localparam logic [15:0] SHORT_OVF_DIVIDEND = 16'h8000;
  localparam logic [15:0] SHORT_OVF_DIVISOR  = 16'hfffe;
  localparam logic [31:0] POS_QUOT_MAX       = 32'h0000_7fff;
  localparam logic [31:0] NEG_QUOT_MAX       = 32'h0000_8000;

  typedef enum logic [1:0] {
    FORM_SIGNED_SHORT          = 2'h0,
    signed_long_quotient_op    = 2'h1,
    unsigned_long_quotient_op  = 2'h2,
    unsigned_short_quotient_op = 2'h3
  } form_t;

  // Condition flags, end-of-table first
  typedef struct packed {
    logic end_table;
    logic zero;
    logic overflow;
    logic carry;
    logic negative;
  } flags_t;

  localparam flags_t FLAGS_RESET = 5'h00;

  // Request from the pipeline: instruction bytes plus operands
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  reg_byte;
    logic [15:0] divisor_operand;
    logic [15:0] pair_low_word;
    logic [15:0] pair_high_word;
  } div_req_t;

  // Words written back to the multiply/divide pair
  typedef struct packed {
    logic [15:0] pair_low_word;
    logic [15:0] pair_high_word;
  } div_res_t;

endpackage

`default_nettype wire

// file: design/div_decode.sv
/*
  Opcode decoder of the divide unit: maps the first instruction byte
  to a divide form. Purely combinational; the caller registers it.
*/
`default_nettype none

module div_decode
  import div_pkg::*;
(
  // Instruction byte
  input  wire logic [7:0] opcode,
  // Decode result
  output logic            valid,
  output form_t           form
);

  // ----------------------------------------------------------------
  // Opcode match
  // ----------------------------------------------------------------
  // Unknown bytes fall back to a harmless form and are flagged invalid
  always_comb begin
    valid = 1'b1;
    form  = FORM_SIGNED_SHORT;
    unique case (opcode)
      OPC_SIGNED_SHORT:   form = FORM_SIGNED_SHORT;
      OPC_SIGNED_LONG:    form = signed_long_quotient_op;
      OPC_UNSIGNED_LONG:  form = unsigned_long_quotient_op;
      OPC_UNSIGNED_SHORT: form = unsigned_short_quotient_op;
      default:            valid = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// file: design/div_unit.sv
/*
  Integer divide unit: four divide forms on the multiply/divide pair,
  restoring divider of one quotient bit per cycle on magnitudes.
  Assumes the pipeline supplies the selected divisor register value
  with the request and holds the pair and flags until done.
*/
// Contract
// - Signed short: low word by divisor
// - Signed long: doubleword by divisor
// - Unsigned long: doubleword by divisor
// - Unsigned short: low word by divisor
// - End-of-table and carry always cleared
// - Zero flag tracks zero quotient
// - Negative flag copies quotient sign bit
// - Signed short overflow: zero divisor, 8000/FFFE
// - Long overflow: quotient too wide, zero divisor
// - Unsigned short overflow: zero divisor only
// - Opcodes 4B, 6B select signed forms
// - Opcodes 7B, 5B select unsigned forms
`default_nettype none

module div_unit
  import div_pkg::*;
#(
  parameter int unsigned DATA_W = WORD_W
)
(
  // Clock, reset, enable
  input  wire logic     clk,
  input  wire logic     sys_rst,
  input  wire logic     ce,
  // Request from the pipeline
  input  wire logic     start,
  input  wire div_req_t req,
  // Answer to the pipeline
  output logic          busy,
  output logic          done,
  output logic          illegal,
  output logic [7:0]    reg_sel,
  output div_res_t      result,
  output flags_t        flags
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DATA_W != 16) begin : g_bad_width
    $error("div_unit serves a 16-bit word only");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_FIN  = 2'b11
  } div_state_t;

  typedef struct packed {
    div_state_t  st;
    logic [4:0]  cnt;
    form_t       form;
    logic [31:0] dvd;       // Shifts out dividend, shifts in quotient
    logic [15:0] rem;
    logic [15:0] dvs;       // Divisor magnitude
    logic [15:0] dvs_raw;
    logic [31:0] orig;      // Dividend as a 32-bit value
    logic        busy;
    logic        done;
    logic        illegal;
    logic [7:0]  sel;
    div_res_t    res;
    flags_t      flags;
  } unit_t;

  unit_t s_q;
  unit_t s_d;

  logic        dec_valid;
  form_t       dec_form;
  logic        accept;
  logic        sgn_in;
  logic [31:0] dvd_in;
  logic [16:0] trial;
  logic        sgn;
  logic        q_neg;
  logic [31:0] q_full;
  logic [15:0] r_word;
  logic        div0;
  logic        ovf;

  div_decode u_decode (
    .opcode (req.opcode),
    .valid  (dec_valid),
    .form   (dec_form)
  );

  // ----------------------------------------------------------------
  // Operand preparation and step arithmetic
  // ----------------------------------------------------------------
  // Signed forms divide magnitudes and fix the signs at the end
  always_comb begin
    accept = start && (s_q.st == ST_IDLE) && dec_valid;
    sgn_in = (dec_form == FORM_SIGNED_SHORT) || (dec_form == signed_long_quotient_op);
    unique case (dec_form)
      FORM_SIGNED_SHORT:          dvd_in = {{16{req.pair_low_word[15]}},
                                            req.pair_low_word};
      unsigned_short_quotient_op: dvd_in = {16'h0000, req.pair_low_word};
      default:                    dvd_in = {req.pair_high_word,
                                            req.pair_low_word};
    endcase
    trial  = {s_q.rem, s_q.dvd[31]} - {1'b0, s_q.dvs};
    sgn    = (s_q.form == FORM_SIGNED_SHORT) || (s_q.form == signed_long_quotient_op);
    q_neg  = sgn && (s_q.orig[31] ^ s_q.dvs_raw[15]);
    q_full = q_neg ? (32'h0 - s_q.dvd) : s_q.dvd;
    // Remainder takes the dividend's sign (truncating division)
    r_word = (sgn && s_q.orig[31]) ? (16'h0 - s_q.rem) : s_q.rem;
    div0   = (s_q.dvs_raw == 16'h0000);
    unique case (s_q.form)
      FORM_SIGNED_SHORT:          ovf = div0 ||
                                        ((s_q.orig[15:0] == SHORT_OVF_DIVIDEND) &&
                                         (s_q.dvs_raw == SHORT_OVF_DIVISOR));
      unsigned_short_quotient_op: ovf = div0;
      unsigned_long_quotient_op:  ovf = div0 || (s_q.dvd[31:16] != 16'h0000);
      default:                    ovf = div0 || (q_neg ? (s_q.dvd > NEG_QUOT_MAX)
                                                       : (s_q.dvd > POS_QUOT_MAX));
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.done    = 1'b0;
    s_d.illegal = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.illegal = start && !dec_valid;
        if (accept) begin
          s_d.st      = ST_RUN;
          s_d.busy    = 1'b1;
          s_d.cnt     = 5'h00;
          s_d.form    = dec_form;
          s_d.sel     = req.reg_byte;
          s_d.orig    = dvd_in;
          s_d.dvs_raw = req.divisor_operand;
          s_d.dvd     = (sgn_in && dvd_in[31]) ? (32'h0 - dvd_in) : dvd_in;
          s_d.dvs     = (sgn_in && req.divisor_operand[15]) ?
                        (16'h0 - req.divisor_operand) : req.divisor_operand;
          s_d.rem     = 16'h0000;
        end
      end
      ST_RUN: begin
        // Restoring step: keep the difference when no borrow
        if (!trial[16]) begin
          s_d.rem = trial[15:0];
          s_d.dvd = {s_q.dvd[30:0], 1'b1};
        end else begin
          s_d.rem = {s_q.rem[14:0], s_q.dvd[31]};
          s_d.dvd = {s_q.dvd[30:0], 1'b0};
        end
        s_d.cnt = s_q.cnt + 5'h01;
        if (s_q.cnt == 5'(DIV_STEPS - 1)) begin
          s_d.st = ST_FIN;
        end
      end
      ST_FIN: begin
        s_d.st                 = ST_IDLE;
        s_d.busy               = 1'b0;
        s_d.done               = 1'b1;
        s_d.res.pair_low_word  = q_full[15:0];
        s_d.res.pair_high_word = r_word;
        s_d.flags.end_table    = 1'b0;
        s_d.flags.carry        = 1'b0;
        s_d.flags.overflow     = ovf;
        s_d.flags.zero         = (q_full[15:0] == 16'h0000);
        s_d.flags.negative     = q_full[15];
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Enable low freezes everything, the divide simply pauses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.form  <= FORM_SIGNED_SHORT;
      s_q.flags <= FLAGS_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign busy    = s_q.busy;
  assign done    = s_q.done;
  assign illegal = s_q.illegal;
  assign reg_sel = s_q.sel;
  assign result  = s_q.res;
  assign flags   = s_q.flags;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_clear_ec;
    @(posedge clk) disable iff (sys_rst)
      done |-> (!flags.end_table && !flags.carry);
  endproperty
  a_clear_ec: assert property (p_clear_ec) else $error("end or carry flag set");

  property p_zero_flag;
    @(posedge clk) disable iff (sys_rst)
      (done && !flags.overflow) |-> (flags.zero == (result.pair_low_word == 16'h0000));
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_neg_flag;
    @(posedge clk) disable iff (sys_rst)
      (done && !flags.overflow) |-> (flags.negative == result.pair_low_word[15]);
  endproperty
  a_neg_flag: assert property (p_neg_flag) else $error("negative flag wrong");

  property p_ss_div0;
    @(posedge clk) disable iff (sys_rst || !ce)
      (accept && dec_form == FORM_SIGNED_SHORT && req.divisor_operand == 16'h0000)
      |-> ##34 (done && flags.overflow);
  endproperty
  a_ss_div0: assert property (p_ss_div0) else $error("zero divisor not flagged");

  property p_us_ovf;
    @(posedge clk) disable iff (sys_rst)
      (done && s_q.form == unsigned_short_quotient_op) |-> (flags.overflow == div0);
  endproperty
  a_us_ovf: assert property (p_us_ovf) else $error("unsigned short overflow wrong");

  property p_ul_fit;
    @(posedge clk) disable iff (sys_rst || !ce)
      (accept && dec_form == unsigned_long_quotient_op &&
       req.pair_high_word < req.divisor_operand) |-> ##34 (done && !flags.overflow);
  endproperty
  a_ul_fit: assert property (p_ul_fit) else $error("unsigned long false overflow");

  property p_us_math;
    @(posedge clk) disable iff (sys_rst)
      (done && s_q.form == unsigned_short_quotient_op && !flags.overflow) |->
      (32'(result.pair_low_word) * 32'(s_q.dvs_raw) + 32'(result.pair_high_word) == s_q.orig);
  endproperty
  a_us_math: assert property (p_us_math) else $error("unsigned short result wrong");

  property p_ul_math;
    @(posedge clk) disable iff (sys_rst)
      (done && s_q.form == unsigned_long_quotient_op && !flags.overflow) |->
      (32'(result.pair_low_word) * 32'(s_q.dvs_raw) + 32'(result.pair_high_word) == s_q.orig);
  endproperty
  a_ul_math: assert property (p_ul_math) else $error("unsigned long result wrong");

  property p_sl_math;
    @(posedge clk) disable iff (sys_rst)
      (done && s_q.form == signed_long_quotient_op && !flags.overflow) |->
      ($signed(result.pair_low_word) * $signed(s_q.dvs_raw) +
       $signed(result.pair_high_word) == $signed(s_q.orig));
  endproperty
  a_sl_math: assert property (p_sl_math) else $error("signed long result wrong");

  property p_ss_sign;
    @(posedge clk) disable iff (sys_rst)
      (done && s_q.form == FORM_SIGNED_SHORT && !flags.overflow && s_q.rem != 16'h0) |->
      (result.pair_high_word[15] == s_q.orig[15]);
  endproperty
  a_ss_sign: assert property (p_ss_sign) else $error("remainder sign wrong");

  property p_illegal;
    @(posedge clk) disable iff (sys_rst || !ce)
      (start && s_q.st == ST_IDLE && !dec_valid) |=> (illegal && !busy);
  endproperty
  a_illegal: assert property (p_illegal) else $error("unknown opcode not refused");

  property p_busy_hold;
    @(posedge clk) disable iff (sys_rst || !ce)
      accept |=> (busy && !done) [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

endmodule

`default_nettype wire

// file: sim/pipe_model.sv
/*
  Model of the decode and execute pipeline in front of the divide unit.
  Assumes the unit shares clk and sys_rst and answers with busy, done
  and illegal as registered outputs.
*/
`default_nettype none

module pipe_model
  import div_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     sys_rst,
  // Answer from the unit
  input  wire logic     busy,
  input  wire logic     done,
  input  wire logic     illegal,
  // Request to the unit
  output var  logic     start,
  output var  div_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    start = 1'b0;
    req   = '0;
  end

  // Hold the request until taken, then scramble it so stale data helps no one
  task automatic run(input div_req_t r, output int cyc, output bit bad);
    @(negedge clk);
    start = 1'b1;
    req   = r;
    do begin
      @(posedge clk);
      #1;
    end while (!busy && !illegal);
    bad = illegal;
    @(negedge clk);
    start = 1'b0;
    req   = ~r;
    cyc   = 1;
    // Pair and flags are left alone until done
    while (!bad && !done) begin
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask

  // Stray request while the unit is busy; it must be ignored
  task automatic poke();
    start = 1'b1;
    req   = '{OPC_SIGNED_SHORT, 8'h77, 16'h0003, 16'h1234, 16'h0000};
    @(negedge clk);
    start = 1'b0;
    req   = ~req;
  endtask
endmodule

`default_nettype wire

// file: sim/tb_top.sv
/*
  Self-checking bench of the divide unit: corner cases with a stray
  request while busy on the first, a refused opcode, then seeded random divides.
  Assumes div_pkg and the pipeline model are compiled first.
*/
`default_nettype none

module tb_top
  import div_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic     clk, sys_rst, ce, start, busy, done, illegal;
  logic [7:0] reg_sel;
  div_req_t req, r;
  div_res_t result, held;
  flags_t   flags;
  int       error_cnt, checks, seed, cyc, tick;
  bit       bad, ce_rand;

  localparam logic [7:0] OPCS [4] = '{OPC_SIGNED_SHORT, OPC_SIGNED_LONG,
                                      OPC_UNSIGNED_LONG, OPC_UNSIGNED_SHORT};
  localparam div_req_t CORNER [13] = '{
    '{OPC_SIGNED_SHORT,   8'h01, 16'hfffe, 16'h8000, 16'h0000},
    '{OPC_SIGNED_SHORT,   8'h02, 16'hffff, 16'h8000, 16'h0000},
    '{OPC_SIGNED_SHORT,   8'h03, 16'h0000, 16'h0005, 16'h0000},
    '{OPC_SIGNED_SHORT,   8'h04, 16'h0007, 16'hfff9, 16'h0000},
    '{OPC_SIGNED_LONG,    8'h05, 16'h0000, 16'h0010, 16'h0000},
    '{OPC_SIGNED_LONG,    8'h06, 16'h0002, 16'h0000, 16'h0001},
    '{OPC_SIGNED_LONG,    8'h07, 16'hffff, 16'h0000, 16'h8000},
    '{OPC_UNSIGNED_LONG,  8'h08, 16'h0002, 16'h0000, 16'h0002},
    '{OPC_UNSIGNED_LONG,  8'h09, 16'h0000, 16'h1111, 16'h0000},
    '{OPC_UNSIGNED_LONG,  8'h0a, 16'hffff, 16'hffff, 16'hfffe},
    '{OPC_UNSIGNED_SHORT, 8'h0b, 16'h0000, 16'h00ff, 16'h0000},
    '{OPC_UNSIGNED_SHORT, 8'h0c, 16'hffff, 16'hfffe, 16'h0000},
    '{OPC_UNSIGNED_SHORT, 8'h0d, 16'h0007, 16'h0005, 16'h0000}};

  div_unit dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .start(start), .req(req),
                  .busy(busy), .done(done), .illegal(illegal), .reg_sel(reg_sel),
                  .result(result), .flags(flags));
  pipe_model pipe_u (.clk(clk), .sys_rst(sys_rst), .busy(busy), .done(done),
                     .illegal(illegal), .start(start), .req(req));

  // ----------------------------------------------------------------
  // Clock, enable and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Random gaps in ce stretch the divide without changing its answer
  always @(negedge clk) ce <= ce_rand ? (($random(seed) & 3) != 0) : 1'b1;

  always @(posedge clk) begin
    tick++;
    if (tick == 20000) begin
      error_cnt++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Reference and checking
  // ----------------------------------------------------------------
  // Returns {overflow, quotient, remainder}
  function automatic logic [32:0] ref_div(div_req_t q_in);
    longint a, b, q, m;
    logic   v;
    a = q_in.pair_low_word;
    b = q_in.divisor_operand;
    if (q_in.opcode == OPC_SIGNED_SHORT) begin
      a = $signed(q_in.pair_low_word);
      b = $signed(q_in.divisor_operand);
    end
    if (q_in.opcode == OPC_SIGNED_LONG) begin
      a = $signed({q_in.pair_high_word, q_in.pair_low_word});
      b = $signed(q_in.divisor_operand);
    end
    if (q_in.opcode == OPC_UNSIGNED_LONG) a = {q_in.pair_high_word, q_in.pair_low_word};
    q = (b == 0) ? 0 : a / b;
    m = (b == 0) ? 0 : a % b;
    v = (b == 0);
    if (q_in.opcode == OPC_SIGNED_SHORT) v |= (a == -32768 && b == -2);
    if (q_in.opcode == OPC_SIGNED_LONG) v |= (q > 32767 || q < -32768);
    if (q_in.opcode == OPC_UNSIGNED_LONG) v |= (q > 65535);
    return {v, q[15:0], m[15:0]};
  endfunction

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic do_op(div_req_t q_in, bit stray);
    logic [32:0] e;
    e = ref_div(q_in);
    if (stray) begin
      fork
        pipe_u.run(q_in, cyc, bad);
        begin
          repeat (12) @(negedge clk);
          pipe_u.poke();
        end
      join
    end else begin
      pipe_u.run(q_in, cyc, bad);
    end
    if (!ce_rand) check("cycles", cyc, 34);
    check("reg_sel", reg_sel, q_in.reg_byte);
    check("flag_e", flags.end_table, 1'b0);
    check("flag_c", flags.carry, 1'b0);
    check("flag_v", flags.overflow, e[32]);
    if (!e[32]) begin
      check("quotient", result.pair_low_word, e[31:16]);
      check("remainder", result.pair_high_word, e[15:0]);
      check("flag_z", flags.zero, e[31:16] == 16'h0000);
      check("flag_n", flags.negative, e[31]);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed    = 45021;
    sys_rst = 1'b1;
    ce_rand = 1'b0;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    check("busy_rst", busy, 1'b0);
    check("done_rst", done, 1'b0);
    foreach (CORNER[i]) do_op(CORNER[i], i == 0);
    $display("test corners finished");
    held    = result;
    r       = CORNER[3];
    r.opcode = 8'h3b;
    pipe_u.run(r, cyc, bad);
    check("illegal", bad, 1'b1);
    check("busy_ill", busy, 1'b0);
    check("result_ill", result, held);
    $display("test refused opcode finished");
    for (int i = 0; i < 48; i++) begin
      ce_rand = (i >= 24);
      r.opcode          = OPCS[i % 4];
      r.reg_byte        = 8'($random(seed));
      r.divisor_operand = 16'($random(seed));
      r.pair_low_word   = 16'($random(seed));
      r.pair_high_word  = 16'($random(seed));
      if (i % 3 != 0) begin
        r.pair_high_word = r.opcode == OPC_SIGNED_LONG ? {16{r.pair_low_word[15]}} : 16'h0000;
      end
      do_op(r, 1'b0);
    end
    ce_rand = 1'b0;
    $display("test random finished");
    results();
  end
endmodule

`default_nettype wire
